// *** phm_pkg.sv ***
// shared types of the management register bank
package phm_pkg;
  typedef logic [15:0] phm_word_type;
  typedef logic [4:0]  phm_addr_type;
  typedef logic [3:0]  phm_irq_type;
endpackage

// *** phm_regbank.sv ***
// management register bank with typed bit access
//
// Contract
// - read-only bits ignore every write
// - locked override bits ignore writes
// - unlock lets next write reach override bits
// - unlock self-clears after the next write
// - read/write bits store written value
// - write-zero-only bits never set by write
// - reset loads every defined default
// - strap pins sampled as reset defaults
// - no-default bits left unreset
// - sticky-high bit holds until read
// - sticky-high bit reloads level after read
// - sticky-low bit holds until read
// - sticky-low bit reloads level after read
// - second read gives present level
// - registers are sixteen bits wide
// - unmapped read gives ffff, write ignored
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "phm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module phm_regbank import phm_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire phm_addr_type addr,
  input  wire phm_word_type wr_data,
  input  wire logic         wr_stb,
  input  wire logic         rd_stb,
  output phm_word_type      rd_data,
  input  wire logic         mdc,
  input  wire logic [2:0]   evt_hi,
  input  wire logic [3:0]   evt_lo_n,
  input  wire logic         addr_strap_led_pin0,
  input  wire logic         addr_strap_led_pin1,
  input  wire logic         addr_strap_led_pin2,
  input  wire logic         addr_strap_led_pin3,
  input  wire logic         addr_strap_led_pin4,
  output phm_word_type      ctrl_word,
  output phm_word_type      gate_word,
  output logic [4:0]        phy_addr,
  output logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic mapped(input phm_addr_type a);
    mapped = (a == `PHM_A_CTRL) || (a == `PHM_A_XCTL)
          || (a == `PHM_A_XSTS) || (a == `PHM_A_GATE)
          || (a == `PHM_A_SCR)  || (a == `PHM_A_ISTS)
          || (a == `PHM_A_IMSK);
  endfunction

  // pin synchronisation
  logic [12:0]  pins_s;
  logic         mdc_s;
  logic [2:0]   evt_hi_s;
  logic [3:0]   evt_lo_n_s;
  logic [4:0]   strap_s;
  logic         mdc_d1_q;
  logic         mdc_rise;

  phm_sync #(.W(13)) u_sync (
    .clk (clk),
    .d   ({mdc, evt_hi, evt_lo_n, addr_strap_led_pin4,
           addr_strap_led_pin3, addr_strap_led_pin2,
           addr_strap_led_pin1, addr_strap_led_pin0}),
    .q   (pins_s)
  );

  assign mdc_s      = pins_s[12];
  assign evt_hi_s   = pins_s[11:9];
  assign evt_lo_n_s = pins_s[8:5];
  assign strap_s    = pins_s[4:0];
  assign mdc_rise   = mdc_s & ~mdc_d1_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      mdc_d1_q <= 1'b0;
    end else begin
      mdc_d1_q <= mdc_s;
    end
  end

  // address decode
  phm_word_type ctrl_q;
  phm_word_type xctl_q;
  phm_word_type gate_q;
  phm_word_type scr_q;
  logic [3:0]   lh_q;
  logic [3:0]   ll_q;
  phm_irq_type  ists_q;
  phm_irq_type  imsk_q;
  phm_word_type rd_data_q;

  wire logic wr_ctrl  = wr_stb & (addr == `PHM_A_CTRL);
  wire logic wr_xctl  = wr_stb & (addr == `PHM_A_XCTL);
  wire logic wr_gate  = wr_stb & (addr == `PHM_A_GATE);
  wire logic wr_scr   = wr_stb & (addr == `PHM_A_SCR);
  wire logic wr_ists  = wr_stb & (addr == `PHM_A_ISTS);
  wire logic wr_imsk  = wr_stb & (addr == `PHM_A_IMSK);
  wire logic rd_xsts  = rd_stb & (addr == `PHM_A_XSTS);
  wire logic unmapped = (wr_stb | rd_stb) & ~mapped(addr);
  wire logic unlock   = xctl_q[`PHM_UNLOCK];

  // control register: upper bits r/w, low bits read-only zero
  phm_word_type ctrl_new;
  phm_word_type ctrl_rst;

  phm_wr_merge u_ctrl (
    .old_val (ctrl_q),
    .wr_val  (wr_data),
    .rw_mask (`PHM_CTRL_RW),
    .cw_mask (16'h0000),
    .w0_mask (16'h0000),
    .unlock  (1'b0),
    .new_val (ctrl_new)
  );

  // isolate defaults high when the strapped address is zero
  assign ctrl_rst = `PHM_CTRL_RST
                  | (phm_word_type'(strap_s == 5'h00) << `PHM_CTRL_ISO);

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= ctrl_rst;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_new;
    end
  end

  // extended control: unlock, strapped address, w0 bits
  phm_word_type xctl_new;
  phm_word_type xctl_upd;
  logic         unlock_d;

  phm_wr_merge u_xctl (
    .old_val (xctl_q),
    .wr_val  (wr_data),
    .rw_mask (`PHM_XCTL_RW),
    .cw_mask (`PHM_XCTL_CW),
    .w0_mask (`PHM_XCTL_W0),
    .unlock  (unlock),
    .new_val (xctl_new)
  );

  assign xctl_upd = wr_xctl ? xctl_new : xctl_q;
  // one write per unlock, any address counts
  assign unlock_d = unlock ? ~wr_stb
                           : (wr_xctl & wr_data[`PHM_UNLOCK]);

  always_ff @(posedge clk) begin
    if (rst) begin
      xctl_q <= `PHM_XCTL_RST
              | (phm_word_type'(strap_s) << `PHM_AD_LSB);
    end else begin
      xctl_q <= {unlock_d, xctl_upd[14:0]};
    end
  end

  // gated configuration register
  phm_word_type gate_new;

  phm_wr_merge u_gate (
    .old_val (gate_q),
    .wr_val  (wr_data),
    .rw_mask (`PHM_GATE_RW),
    .cw_mask (`PHM_GATE_CW),
    .w0_mask (16'h0000),
    .unlock  (unlock),
    .new_val (gate_new)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_q <= `PHM_GATE_RST;
    end else if (wr_gate) begin
      gate_q <= gate_new;
    end
  end

  // scratch word without a default
  always_ff @(posedge clk) begin
    if (wr_scr) begin
      scr_q <= wr_data;
    end
  end

  // sticky event bits
  logic [3:0] lh_sig;
  assign lh_sig = {evt_hi_s, mdc_rise};

  always_ff @(posedge clk) begin
    if (rst) begin
      lh_q <= `PHM_LH_RST;
      ll_q <= `PHM_LL_RST;
    end else begin
      lh_q <= rd_xsts ? lh_sig : (lh_q | lh_sig);
      ll_q <= rd_xsts ? evt_lo_n_s : (ll_q & evt_lo_n_s);
    end
  end

  // interrupt events, set wins over clear
  phm_irq_type ev;
  phm_irq_type clr;

  assign ev[`PHM_IRQ_LH]    = |(lh_sig & ~lh_q);
  assign ev[`PHM_IRQ_LL]    = |(~evt_lo_n_s & ll_q);
  assign ev[`PHM_IRQ_LOCK]  = ~unlock
    & ((wr_xctl & |((wr_data ^ xctl_q) & `PHM_XCTL_CW))
     | (wr_gate & |((wr_data ^ gate_q) & `PHM_GATE_CW)));
  assign ev[`PHM_IRQ_UNMAP] = unmapped;
  assign clr = wr_ists ? wr_data[3:0] : 4'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      ists_q <= 4'h0;
      imsk_q <= 4'h0;
    end else begin
      ists_q <= ev | (ists_q & ~clr);
      if (wr_imsk) begin
        imsk_q <= wr_data[3:0];
      end
    end
  end

  // read path
  phm_word_type rd_word;
  assign rd_word =
      (addr == `PHM_A_CTRL) ? ctrl_q
    : (addr == `PHM_A_XCTL) ? xctl_q
    : (addr == `PHM_A_XSTS) ? {lh_q, 8'h00, ll_q}
    : (addr == `PHM_A_GATE) ? gate_q
    : (addr == `PHM_A_SCR)  ? scr_q
    : (addr == `PHM_A_ISTS) ? {12'h000, ists_q}
    : (addr == `PHM_A_IMSK) ? {12'h000, imsk_q}
    : `PHM_UNMAPPED;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= rd_stb ? rd_word : 16'h0000;
    end
  end

  assign rd_data   = rd_data_q;
  assign ctrl_word = ctrl_q;
  assign gate_word = gate_q;
  assign phy_addr  = xctl_q[10:6];
  assign irq       = |(ists_q & imsk_q);

  // checks
  sequence s_locked_gate_wr;
    wr_gate && !unlock;
  endsequence

  sequence s_open_gate_wr;
    wr_gate && unlock;
  endsequence

  sequence s_two_reads;
    rd_xsts ##1 rd_xsts;
  endsequence

  property p_ro_ctrl;
    wr_ctrl |=> ctrl_q[6:0] == $past(ctrl_q[6:0]);
  endproperty
  a_ro_ctrl: assert property (p_ro_ctrl)
    else $error("read-only bits changed");

  property p_locked;
    s_locked_gate_wr |=> gate_q[15:8] == $past(gate_q[15:8]);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked bits changed");

  property p_open;
    s_open_gate_wr |=> gate_q[15:8] == $past(wr_data[15:8]);
  endproperty
  a_open: assert property (p_open)
    else $error("unlocked write not applied");

  property p_unlock_once;
    unlock && wr_stb |=> !unlock;
  endproperty
  a_unlock_once: assert property (p_unlock_once)
    else $error("unlock survived a write");

  property p_rw;
    wr_scr |=> scr_q == $past(wr_data);
  endproperty
  a_rw: assert property (p_rw)
    else $error("r/w word not stored");

  property p_w0;
    !$past(rst) |-> (xctl_q & ~$past(xctl_q) & `PHM_XCTL_W0) == 16'h0000;
  endproperty
  a_w0: assert property (p_w0)
    else $error("write-zero-only bit was set");

  property p_defaults;
    $fell(rst) |-> gate_q == `PHM_GATE_RST && lh_q == `PHM_LH_RST
      && ll_q == `PHM_LL_RST && ctrl_q[`PHM_CTRL_ISO] == (phy_addr == 5'h00);
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("default not loaded");

  property p_strap;
    $fell(rst) |-> phy_addr == $past(strap_s);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not captured");

  property p_lh_hold;
    (lh_q != 4'h0) && !rd_xsts |=> (lh_q & $past(lh_q)) == $past(lh_q);
  endproperty
  a_lh_hold: assert property (p_lh_hold)
    else $error("sticky-high bit dropped");

  property p_lh_reload;
    rd_xsts |=> lh_q == $past(lh_sig);
  endproperty
  a_lh_reload: assert property (p_lh_reload)
    else $error("sticky-high not reloaded");

  property p_ll_hold;
    !rd_xsts |=> (ll_q | $past(ll_q)) == $past(ll_q);
  endproperty
  a_ll_hold: assert property (p_ll_hold)
    else $error("sticky-low bit rose unread");

  property p_ll_reload;
    rd_xsts |=> ll_q == $past(evt_lo_n_s);
  endproperty
  a_ll_reload: assert property (p_ll_reload)
    else $error("sticky-low not reloaded");

  property p_second_read;
    s_two_reads |=> rd_data[15:12] == $past(lh_sig, 2);
  endproperty
  a_second_read: assert property (p_second_read)
    else $error("second read not present level");

  property p_unmapped;
    rd_stb && !mapped(addr) |=> rd_data == `PHM_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not ffff");
endmodule
`default_nettype wire

// *** phm_regs.svh ***
// register offsets, field positions, masks and reset values
`ifndef PHM_REGS_SVH
`define PHM_REGS_SVH
`define PHM_A_CTRL    5'h00
`define PHM_A_XCTL    5'h10
`define PHM_A_XSTS    5'h11
`define PHM_A_GATE    5'h12
`define PHM_A_SCR     5'h13
`define PHM_A_ISTS    5'h14
`define PHM_A_IMSK    5'h15
`define PHM_UNMAPPED  16'hffff
`define PHM_CTRL_RW   16'hff80
`define PHM_CTRL_RST  16'h3000
`define PHM_CTRL_ISO  10
`define PHM_XCTL_RW   16'h0030
`define PHM_XCTL_CW   16'h07c0
`define PHM_XCTL_W0   16'h000f
`define PHM_XCTL_RST  16'h000f
`define PHM_UNLOCK    15
`define PHM_AD_LSB    6
`define PHM_GATE_RW   16'h00ff
`define PHM_GATE_CW   16'hff00
`define PHM_GATE_RST  16'h0000
`define PHM_LH_RST    4'h0
`define PHM_LL_RST    4'hf
`define PHM_IRQ_LH    0
`define PHM_IRQ_LL    1
`define PHM_IRQ_LOCK  2
`define PHM_IRQ_UNMAP 3
`endif

// *** phm_sta_model.sv ***
// station side model: management clock source for the link
`timescale 1ns/1ps
`default_nettype none
module phm_sta_model (
  input  wire logic run,
  output logic      mdc
);
  initial mdc = 1'b0;
  // 320 ns period while a frame runs, stands low between frames
  always begin
    #160;
    mdc = run ? ~mdc : 1'b0;
  end
endmodule
`default_nettype wire

// *** phm_sync.sv ***
// two-flop synchroniser for pins and the management clock
`timescale 1ns/1ps
`default_nettype none
module phm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // no reset: straps must be visible while reset is held
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule
`default_nettype wire

// *** phm_wr_merge.sv ***
// per-bit write merge by access type
`timescale 1ns/1ps
`default_nettype none
module phm_wr_merge import phm_pkg::*; (
  input  wire phm_word_type old_val,
  input  wire phm_word_type wr_val,
  input  wire phm_word_type rw_mask,
  input  wire phm_word_type cw_mask,
  input  wire phm_word_type w0_mask,
  input  wire logic         unlock,
  output phm_word_type      new_val
);
  phm_word_type wmask;

  assign wmask   = rw_mask | (cw_mask & {16{unlock}});
  assign new_val = (old_val & ~wmask & ~w0_mask)
                 | (wr_val & wmask)
                 | (old_val & wr_val & w0_mask);
endmodule
`default_nettype wire

// *** phy_mgmt_register_bit_access_bench.sv ***
// self-checking bench of the management register bank
`timescale 1ns/1ps
`default_nettype none
`include "phm_regs.svh"
module phy_mgmt_register_bit_access_bench import phm_pkg::*;;
  logic         clk, rst, wr_stb, rd_stb, run, mdc, irq;
  phm_addr_type addr;
  phm_word_type wr_data, rd_data, ctrl_word, gate_word, got, rnd, cw;
  logic [2:0]   evt_hi;
  logic [3:0]   evt_lo_n;
  logic [4:0]   strap, phy_addr;
  int           error_cnt, checked, k;
  int           cycles = 0;

  phm_regbank dut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .mdc(mdc),
    .evt_hi(evt_hi), .evt_lo_n(evt_lo_n),
    .addr_strap_led_pin0(strap[0]), .addr_strap_led_pin1(strap[1]),
    .addr_strap_led_pin2(strap[2]), .addr_strap_led_pin3(strap[3]),
    .addr_strap_led_pin4(strap[4]), .ctrl_word(ctrl_word),
    .gate_word(gate_word), .phy_addr(phy_addr), .irq(irq)
  );
  phm_sta_model sta (.run(run), .mdc(mdc));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  function automatic phm_word_type ctrl_dflt(input logic [4:0] s);
    return `PHM_CTRL_RST | ((s == 5'h00) ? (16'h1 << `PHM_CTRL_ISO) : 16'h0);
  endfunction
  function automatic phm_word_type xctl_dflt(input logic [4:0] s);
    return `PHM_XCTL_RST | (16'(s) << `PHM_AD_LSB);
  endfunction

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input phm_word_type g, input phm_word_type e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input phm_addr_type a, input phm_word_type d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input phm_addr_type a, input phm_word_type e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 got = rd_data;
    chk(got, e);
    @(posedge clk);
  endtask
  // two reads of the sticky word with no gap between them
  task automatic rd2_chk(input phm_word_type e1, input phm_word_type e2);
    addr <= `PHM_A_XSTS;
    rd_stb <= 1'b1;
    @(posedge clk);
    #1 got = rd_data;
    chk(got, e1);
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 got = rd_data;
    chk(got, e2);
    @(posedge clk);
  endtask
  task automatic do_reset(input logic [4:0] s);
    strap <= s;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_dflt();
    rd_chk(`PHM_A_CTRL, ctrl_dflt(strap));
    chk(ctrl_word, ctrl_dflt(strap));
    rd_chk(`PHM_A_XCTL, xctl_dflt(strap));
    chk({11'h0, phy_addr}, {11'h0, strap});
    rd_chk(`PHM_A_XSTS, 16'h000f);
    rd_chk(`PHM_A_GATE, `PHM_GATE_RST);
    rd_chk(`PHM_A_ISTS, 16'h0000);
    rd_chk(`PHM_A_IMSK, 16'h0000);
  endtask
  // pulse or hold events, then two reads in succession
  task automatic sticky(input logic [2:0] h, input logic [3:0] l,
                        input logic m, input logic hold,
                        input phm_word_type e);
    evt_hi <= h;
    evt_lo_n <= l;
    run <= m;
    repeat (24) @(posedge clk);
    run <= 1'b0;
    if (!hold) begin
      evt_hi <= 3'h0;
      evt_lo_n <= 4'hf;
    end
    repeat (12) @(posedge clk);
    rd2_chk(e, hold ? e : 16'h000f);
    evt_hi <= 3'h0;
    evt_lo_n <= 4'hf;
    repeat (6) @(posedge clk);
    // held level stays sticky after the pin drops; this read clears it
    rd_chk(`PHM_A_XSTS, hold ? e : 16'h000f);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    rst = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 5'h00;
    wr_data = 16'h0000;
    evt_hi = 3'h0;
    evt_lo_n = 4'hf;
    run = 1'b0;
    strap = 5'h00;
    error_cnt = 0;
    checked = 0;
    void'($urandom(32'hc9b57598));
    do_reset(5'($urandom_range(31, 1)));
    chk_dflt();
    // unmapped place reads all ones, write lands nowhere
    wr(5'h1f, 16'h1234);
    rd_chk(5'h1f, `PHM_UNMAPPED);
    rd_chk(`PHM_A_GATE, 16'h0000);
    wr(`PHM_A_XSTS, 16'hf00f);
    rd_chk(`PHM_A_XSTS, 16'h000f);
    wr(`PHM_A_CTRL, 16'h7f00);
    rd_chk(`PHM_A_CTRL, 16'h7f00);
    chk(ctrl_word, 16'h7f00);
    cw = xctl_dflt(strap) & `PHM_XCTL_CW;
    wr(`PHM_A_XCTL, 16'h0000);
    rd_chk(`PHM_A_XCTL, cw);
    wr(`PHM_A_XCTL, 16'h003f);
    rd_chk(`PHM_A_XCTL, cw | 16'h0030);
    // one unlock covers exactly one write
    rnd = 16'($urandom);
    wr(`PHM_A_XCTL, 16'h8030 | cw);
    wr(`PHM_A_GATE, rnd);
    chk(gate_word, rnd);
    rd_chk(`PHM_A_XCTL, 16'h0030 | cw);
    wr(`PHM_A_GATE, ~rnd);
    rd_chk(`PHM_A_GATE, {rnd[15:8], ~rnd[7:0]});
    wr(`PHM_A_XCTL, 16'h8030);
    wr(`PHM_A_XCTL, {11'h0, ~strap} << `PHM_AD_LSB);
    chk({11'h0, phy_addr}, {11'h0, ~strap});
    for (int i = 0; i < 8; i++) begin
      rnd = 16'($urandom);
      wr(`PHM_A_SCR, rnd);
      rd_chk(`PHM_A_SCR, rnd);
    end
    k = $urandom_range(2, 0);
    sticky(3'h1 << k, 4'hf, 1'b0, 1'b0, (16'h2000 << k) | 16'h000f);
    sticky(3'h1 << k, 4'hf, 1'b0, 1'b1, (16'h2000 << k) | 16'h000f);
    k = $urandom_range(3, 0);
    sticky(3'h0, ~(4'h1 << k), 1'b0, 1'b0, 16'h000f & ~(16'h1 << k));
    sticky(3'h0, ~(4'h1 << k), 1'b0, 1'b1, 16'h000f & ~(16'h1 << k));
    sticky(3'h0, 4'hf, 1'b1, 1'b0, 16'h100f);
    // status, mask and level output
    rd_chk(`PHM_A_ISTS, 16'h000f);
    chk({15'h0, irq}, 16'h0000);
    wr(`PHM_A_IMSK, 16'h0002);
    chk({15'h0, irq}, 16'h0001);
    wr(`PHM_A_ISTS, 16'h000f);
    rd_chk(`PHM_A_ISTS, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    do_reset(5'h00);
    chk_dflt();
    finish_test();
  end
endmodule
`default_nettype wire
